//--- common/tei_pkg.sv
package tei_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_ERR_COUNT  = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_INT_STAT   = 8'h0c;
  localparam logic [7:0] REG_INT_MASK   = 8'h10;
  localparam logic [7:0] REG_CNT_DATA   = 8'h14;
  localparam logic [7:0] REG_CNT_BIPOL  = 8'h18;
  localparam logic [7:0] REG_CNT_FRAME  = 8'h1c;
  localparam logic [7:0] REG_CNT_CRC    = 8'h20;
  localparam logic [7:0] REG_CNT_ALIGN  = 8'h24;
  localparam logic [7:0] REG_TRIGGER    = 8'h28;

  // ==========================================================================
  // Control register fields.
  localparam int CTRL_RATE_LSB   = 0;
  localparam int CTRL_LOCN_LSB   = 4;
  localparam int CTRL_INTERNAL   = 6;
  localparam int CTRL_MEAS       = 7;
  localparam int CTRL_MONLOOP    = 8;
  localparam int CTRL_FRAMED     = 9;

  // ==========================================================================
  // Reset values and limits.
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [10:0] ERR_COUNT_MAX  = 11'h608;
  localparam logic [31:0] CNT_MAX        = 32'h05f5_e0ff;
  localparam logic [31:0] CNT_BLANK      = 32'hffff_ffff;
  localparam logic [2:0]  RESP_OKAY      = 3'h0;
  localparam logic [1:0]  AXI_OKAY       = 2'h0;
  localparam logic [1:0]  AXI_SLVERR     = 2'h2;

  // ==========================================================================
  // Rate periods in bits.
  localparam logic [23:0] PER_1E3 = 24'h0003e8;
  localparam logic [23:0] PER_1E4 = 24'h002710;
  localparam logic [23:0] PER_1E5 = 24'h0186a0;
  localparam logic [23:0] PER_1E6 = 24'h0f4240;
  localparam logic [23:0] PER_1E7 = 24'h989680;

  typedef enum logic [2:0] {
    TEI_RATE_OFF = 3'b000,
    TEI_RATE_1E3 = 3'b001,
    TEI_RATE_1E4 = 3'b010,
    TEI_RATE_1E5 = 3'b011,
    TEI_RATE_1E6 = 3'b100,
    TEI_RATE_1E7 = 3'b101
  } tei_rate_t;

  typedef enum logic [1:0] {
    TEI_LOC_NONE    = 2'b00,
    TEI_LOC_PAYLOAD = 2'b01,
    TEI_LOC_FRAMING = 2'b10
  } tei_locn_t;

  typedef enum logic [1:0] {
    TEI_MS_STOP    = 2'b00,
    TEI_MS_WAIT    = 2'b01,
    TEI_MS_RUNNING = 2'b10
  } tei_meas_t;

  // Per-bit line events from the receive framer.
  typedef struct packed {
    logic bit_valid;
    logic data_err;
    logic bipolar_violation;
    logic frame_err;
    logic crc_err;
    logic frame_alignment_change;
    logic frame_sync;
    logic pattern_sync;
    logic remote_alarm;
  } tei_line_t;

  // Injection strobes toward the transmitter.
  typedef struct packed {
    logic payload_err;
    logic framing_bit_error_target;
  } tei_inj_t;

  function automatic logic [23:0] tei_rate_period(input tei_rate_t r);
    case (r)
      TEI_RATE_1E3: tei_rate_period = PER_1E3;
      TEI_RATE_1E4: tei_rate_period = PER_1E4;
      TEI_RATE_1E5: tei_rate_period = PER_1E5;
      TEI_RATE_1E6: tei_rate_period = PER_1E6;
      default:      tei_rate_period = PER_1E7;
    endcase
  endfunction : tei_rate_period

endpackage : tei_pkg

//--- core/tei_counter.sv
`timescale 1ns/1ps
module tei_counter
  import tei_pkg::*;
(
  // Clock and reset.
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // Control.
  input  wire  logic        clear,
  input  wire  logic        inc,
  // Count.
  output logic [31:0]       count
);

  typedef struct packed {
    logic [31:0] cnt;
  } tei_cnt_state_t;

  tei_cnt_state_t cur_ff;
  tei_cnt_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (clear) begin
      nxt_cur.cnt = 32'h0000_0000; // R14
    end else if (inc && cur_ff.cnt != CNT_MAX) begin
      nxt_cur.cnt = cur_ff.cnt + 32'h0000_0001; // R14
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign count = cur_ff.cnt;

  AST_CNT_SATURATE: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (cur_ff.cnt == CNT_MAX && !clear) |=> cur_ff.cnt == CNT_MAX)
    else $error("Counter wrapped past its maximum.");

endmodule : tei_counter

//--- core/tei_error_inject.sv
// Summary of operation
// R1 - Software sets an error count from 0 to 1544 per insertion.
// R2 - Each trigger write sends exactly the configured number of errors again; a trigger in a cycle that counts a pending error down is ignored.
// R3 - Count and rate insertion never run together; a nonzero count blocks the rate.
// R4 - Rate injection runs at one error per 1E3 to 1E7 bits, or is off by default.
// R5 - Software picks payload or framing target whenever count or rate is set.
// R6 - Payload target corrupts payload bits, framing target corrupts framing bits.
// R7 - No-target location means count zero and rate off, and is the default.
// R8 - Five eight-digit counters for data, bipolar, frame, CRC and alignment changes.
// R9 - Frame sync, pattern sync and remote alarm flags track line status.
// R10 - Counters show values only while a measurement runs, else read blank.
// R11 - Injection settings act only while line coding is internal.
// R12 - In monitor or loop modes only frame sync starts; data errors blank until pattern sync.
// R13 - A start waits for pattern sync, and frame sync when framed, before counting.
// R14 - Counters clear at each start and saturate instead of wrapping.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module tei_error_inject
  import tei_pkg::*;
(
  // Clock and reset.
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // AXI4-Lite write channels.
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Line side.
  input  wire  tei_line_t   line_in,
  output tei_inj_t          inj_out,
  output logic              remote_alarm_flag,
  // Interrupt.
  output logic              irq
);

  // ==========================================================================
  // State.
  typedef struct packed {
    tei_line_t   ln1;
    tei_line_t   ln2;
    logic        awv;
    logic [7:0]  awa;
    logic        wv;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [31:0] ctrl;
    logic [10:0] err_count;
    logic [10:0] remain;
    logic [23:0] rate_cnt;
    tei_meas_t   meas;
    logic [4:0]  ist;
    logic [4:0]  imask;
    tei_inj_t    inj;
    logic        irq;
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
  } tei_state_t;

  tei_state_t cur_ff;
  tei_state_t nxt_cur;

  logic [31:0] cnt_val [5];
  logic [4:0]  cnt_inc;
  logic        cnt_clr;
  tei_rate_t   rate;
  tei_locn_t   locn;
  logic        internal;
  logic        sync_ok;
  logic        running;
  logic        inj_en;
  logic        do_wr_any;

  assign rate     = tei_rate_t'(cur_ff.ctrl[CTRL_RATE_LSB +: 3]);
  assign locn     = tei_locn_t'(cur_ff.ctrl[CTRL_LOCN_LSB +: 2]);
  assign internal = cur_ff.ctrl[CTRL_INTERNAL];
  assign running  = cur_ff.meas == TEI_MS_RUNNING;
  assign sync_ok  = cur_ff.ctrl[CTRL_MONLOOP] ? cur_ff.ln2.frame_sync // R12
                  : (cur_ff.ln2.pattern_sync
                     && (!cur_ff.ctrl[CTRL_FRAMED] || cur_ff.ln2.frame_sync)); // R13
  assign cnt_clr  = cur_ff.meas == TEI_MS_WAIT;
  assign inj_en   = internal && cur_ff.ln2.bit_valid && locn != TEI_LOC_NONE; // R11 R7
  assign do_wr_any = cur_ff.awv && cur_ff.wv && !cur_ff.bv;
  assign cnt_inc  = {5{running && cur_ff.ln2.bit_valid}}
                  & {cur_ff.ln2.frame_alignment_change, cur_ff.ln2.crc_err,
                     cur_ff.ln2.frame_err, cur_ff.ln2.bipolar_violation,
                     cur_ff.ln2.data_err && cur_ff.ln2.pattern_sync}; // R8

  // ==========================================================================
  // Error counters.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_cnt
      tei_counter u_cnt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clear   (cnt_clr),
        .inc     (cnt_inc[gi]),
        .count   (cnt_val[gi])
      );
    end
  endgenerate

  function automatic logic [31:0] blank_or(input logic show, input logic [31:0] v);
    blank_or = show ? v : CNT_BLANK;
  endfunction : blank_or

  // ==========================================================================
  // Next state.
  always_comb begin
    logic [31:0] rdv;
    logic        hit;
    logic [4:0]  ev;
    rdv     = 32'h0000_0000;
    hit     = 1'b1;
    ev      = 5'h00;
    nxt_cur = cur_ff;
    nxt_cur.ln1 = line_in;
    nxt_cur.ln2 = cur_ff.ln1;
    nxt_cur.inj = '0;

    if (s_axi_awvalid && s_axi_awready) begin
      nxt_cur.awv = 1'b1;
      nxt_cur.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_cur.wv = 1'b1;
      nxt_cur.wd = s_axi_wdata;
      nxt_cur.ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_cur.bv = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_cur.rv = 1'b0;
    end

    if (do_wr_any) begin
      nxt_cur.awv = 1'b0;
      nxt_cur.wv  = 1'b0;
      nxt_cur.bv  = 1'b1;
      nxt_cur.br  = AXI_OKAY;
      if (cur_ff.awa == REG_CTRL) begin
        nxt_cur.ctrl = cur_ff.wd & 32'h0000_03f7;
        if (cur_ff.wd[CTRL_MEAS +: 1] == 1'b0) begin
          nxt_cur.meas = TEI_MS_STOP;
        end else if (cur_ff.meas == TEI_MS_STOP) begin
          nxt_cur.meas = TEI_MS_WAIT; // R13
        end
      end else if (cur_ff.awa == REG_ERR_COUNT) begin
        if (cur_ff.wd <= {21'h000000, ERR_COUNT_MAX}) begin
          nxt_cur.err_count = cur_ff.wd[10:0]; // R1
        end else begin
          nxt_cur.br = AXI_SLVERR;
        end
      end else if (cur_ff.awa == REG_TRIGGER) begin
        nxt_cur.remain = cur_ff.err_count; // R2
      end else if (cur_ff.awa == REG_INT_STAT) begin
        nxt_cur.ist = cur_ff.ist & ~cur_ff.wd[4:0];
      end else if (cur_ff.awa == REG_INT_MASK) begin
        nxt_cur.imask = cur_ff.wd[4:0];
      end else begin
        nxt_cur.br = AXI_SLVERR;
      end
    end

    if (s_axi_arvalid && s_axi_arready) begin
      nxt_cur.rv = 1'b1;
      if (s_axi_araddr == REG_CTRL) begin
        rdv = cur_ff.ctrl;
      end else if (s_axi_araddr == REG_ERR_COUNT) begin
        rdv = {21'h000000, cur_ff.err_count};
      end else if (s_axi_araddr == REG_STATUS) begin
        rdv = {27'h0000000, cur_ff.meas, cur_ff.ln2.remote_alarm,
               cur_ff.ln2.pattern_sync, cur_ff.ln2.frame_sync}; // R9
      end else if (s_axi_araddr == REG_INT_STAT) begin
        rdv = {27'h0000000, cur_ff.ist};
      end else if (s_axi_araddr == REG_INT_MASK) begin
        rdv = {27'h0000000, cur_ff.imask};
      end else if (s_axi_araddr == REG_CNT_DATA) begin
        rdv = blank_or(running && cur_ff.ln2.pattern_sync, cnt_val[0]); // R12
      end else if (s_axi_araddr == REG_CNT_BIPOL) begin
        rdv = blank_or(running, cnt_val[1]); // R10
      end else if (s_axi_araddr == REG_CNT_FRAME) begin
        rdv = blank_or(running, cnt_val[2]); // R10
      end else if (s_axi_araddr == REG_CNT_CRC) begin
        rdv = blank_or(running, cnt_val[3]); // R10
      end else if (s_axi_araddr == REG_CNT_ALIGN) begin
        rdv = blank_or(running, cnt_val[4]); // R10
      end else begin
        hit = 1'b0;
      end
      nxt_cur.rd = rdv;
      nxt_cur.rr = hit ? AXI_OKAY : AXI_SLVERR;
    end

    if (cur_ff.meas == TEI_MS_WAIT && sync_ok) begin
      nxt_cur.meas = TEI_MS_RUNNING; // R13
    end

    // Injection: count first; rate only when no count is pending or set.
    if (!internal || locn == TEI_LOC_NONE) begin
      nxt_cur.remain = 11'h000; // R7
    end else if (inj_en && cur_ff.remain != 11'h000) begin
      nxt_cur.remain = cur_ff.remain - 11'h001;
      nxt_cur.inj.payload_err              = locn == TEI_LOC_PAYLOAD; // R6
      nxt_cur.inj.framing_bit_error_target = locn == TEI_LOC_FRAMING; // R6
    end
    if (rate == TEI_RATE_OFF || cur_ff.err_count != 11'h000 || cur_ff.remain != 11'h000
        || !inj_en) begin // R3 R4
      if (rate == TEI_RATE_OFF || cur_ff.err_count != 11'h000 || cur_ff.remain != 11'h000) begin
        nxt_cur.rate_cnt = 24'h000000;
      end
    end else if (cur_ff.rate_cnt + 24'h000001 >= tei_rate_period(rate)) begin
      nxt_cur.rate_cnt = 24'h000000;
      nxt_cur.inj.payload_err              = locn == TEI_LOC_PAYLOAD; // R6
      nxt_cur.inj.framing_bit_error_target = locn == TEI_LOC_FRAMING; // R6
    end else begin
      nxt_cur.rate_cnt = cur_ff.rate_cnt + 24'h000001; // R4
    end

    ev = {cur_ff.ln2.remote_alarm && !cur_ff.ln1.remote_alarm ? 1'b0
            : (cur_ff.ln1.remote_alarm && !cur_ff.ln2.remote_alarm),
          cur_ff.ln1.pattern_sync && !cur_ff.ln2.pattern_sync,
          cur_ff.ln1.frame_sync && !cur_ff.ln2.frame_sync,
          cur_ff.meas == TEI_MS_WAIT && sync_ok,
          cur_ff.remain == 11'h001 && inj_en};
    nxt_cur.ist = nxt_cur.ist | ev;
    nxt_cur.irq = |(nxt_cur.ist & nxt_cur.imask);
    nxt_cur.awrdy = !nxt_cur.awv && !nxt_cur.bv;
    nxt_cur.wrdy  = !nxt_cur.wv && !nxt_cur.bv;
    nxt_cur.arrdy = !nxt_cur.rv;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff      <= '0;
      cur_ff.ctrl <= CTRL_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================================
  // Outputs.
  assign s_axi_awready     = cur_ff.awrdy;
  assign s_axi_wready      = cur_ff.wrdy;
  assign s_axi_bvalid      = cur_ff.bv;
  assign s_axi_bresp       = cur_ff.br;
  assign s_axi_arready     = cur_ff.arrdy;
  assign s_axi_rvalid      = cur_ff.rv;
  assign s_axi_rdata       = cur_ff.rd;
  assign s_axi_rresp       = cur_ff.rr;
  assign inj_out           = cur_ff.inj;
  assign remote_alarm_flag = cur_ff.ln2.remote_alarm; // R9
  assign irq               = cur_ff.irq;

  // ==========================================================================
  // Checks.
  sequence s_start;
    cur_ff.meas == TEI_MS_WAIT && sync_ok;
  endsequence

  AST_NO_DUAL_INJECT: assert property (@(posedge clk) disable iff (sys_rst) // R3
    !(inj_out.payload_err && inj_out.framing_bit_error_target))
    else $error("Both injection targets strobed together.");
  AST_RATE_BLOCKED: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (cur_ff.err_count != 11'h000 && cur_ff.remain == 11'h000) |=> !(|inj_out))
    else $error("Rate injection ran while a count was set.");
  AST_LOCN_NONE: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (locn == TEI_LOC_NONE) |=> !(|inj_out))
    else $error("Injection with no target.");
  AST_EXTERNAL: assert property (@(posedge clk) disable iff (sys_rst) // R11
    !internal |=> !(|inj_out))
    else $error("Injection while line coding not internal.");
  AST_TARGET: assert property (@(posedge clk) disable iff (sys_rst) // R6
    inj_out.payload_err |-> $past(locn) == TEI_LOC_PAYLOAD)
    else $error("Payload error with wrong target.");
  AST_START: assert property (@(posedge clk) disable iff (sys_rst) // R13
    s_start |=> running)
    else $error("Measurement did not start on sync.");
  AST_WAIT: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (cur_ff.meas == TEI_MS_WAIT && !sync_ok) |=> !running)
    else $error("Measurement started without sync.");
  AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R14
    s_start |=> cnt_val[1] == 32'h0000_0000)
    else $error("Counter not cleared at start.");
  AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (cur_ff.remain != 11'h000 && inj_en && !do_wr_any)
    |=> cur_ff.remain == $past(cur_ff.remain) - 11'h001)
    else $error("Insertion count did not advance.");
  AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
    (|(cur_ff.ist & cur_ff.imask)) |-> irq)
    else $error("Interrupt low with pending status.");

endmodule : tei_error_inject

//--- testbench/tb_t1_error_inject_and_count.sv
`timescale 1ns/1ps
module tb_t1_error_inject_and_count
  import tei_pkg::*;
;
  typedef struct packed {logic [33:0] v; logic [33:0] m;} tei_exp_t;

  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  err_cmd = '0;
  logic [2:0]  sync_cmd = '0;
  logic        slow = 1'b0, remote_alarm_flag, irq;
  tei_line_t   line_in;
  tei_inj_t    inj_out;
  logic [15:0] lfsr = 16'he955;
  logic [33:0] got;
  tei_exp_t    w_e, exp_q[$];
  string       w_n, name_q[$];
  int          num_errors = 0, checks_done = 0, np = 0, nf = 0, cyc = 0, t0 = 0, t1 = 0, n;

  always #12.5 clk = ~clk;

  tei_error_inject tei_error_inject_inst (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_in(line_in),
    .inj_out(inj_out), .remote_alarm_flag(remote_alarm_flag), .irq(irq));

  tei_line_model tei_line_model_inst (
    .clk(clk), .sys_rst(sys_rst), .err_cmd(err_cmd), .sync_cmd(sync_cmd), .slow(slow),
    .line_in(line_in));

  // ==========================================================================
  // Helpers.
  function automatic logic [15:0] lfsr_step(input logic [15:0] x);
    lfsr_step = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_step

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back('{{r, 32'h0}, {2'b11, 32'h0}});
    name_q.push_back("bresp");
    lfsr = lfsr_step(lfsr);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_wstrb <= lfsr[3:0];
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = AXI_OKAY);
    exp_q.push_back('{{r, d}, {2'b11, (r == AXI_OKAY) ? 32'hffff_ffff : 32'h0}});
    name_q.push_back(nm);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [4:0] c);
    @(posedge clk);
    err_cmd <= c;
    @(posedge clk);
    err_cmd <= '0;
  endtask : pulse

  task automatic burst(input int cnt, input int ep, input int ef);
    wr(REG_INT_STAT, 32'h1, AXI_OKAY);
    wr(REG_ERR_COUNT, 32'(cnt), AXI_OKAY);
    np = 0;
    nf = 0;
    wr(REG_TRIGGER, 32'h1, AXI_OKAY);
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    chk("payload_pulses", 32'(ep), 32'(np));
    chk("framing_pulses", 32'(ef), 32'(nf));
  endtask : burst

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle

  // ==========================================================================
  // Response watcher and injection pulse counter.
  always @(posedge clk) begin
    cyc++;
    if (inj_out.payload_err === 1'b1) begin
      np++;
      t0 = t1;
      t1 = cyc;
    end
    if (inj_out.framing_bit_error_target === 1'b1) nf++;
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      w_e = exp_q.pop_front();
      w_n = name_q.pop_front();
      got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
      checks_done++;
      if ((got & w_e.m) !== w_e.v) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", w_n, w_e.v, got & w_e.m);
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd("ctrl", REG_CTRL, CTRL_RST);
    rd("cnt_data", REG_CNT_DATA, CNT_BLANK);
    rd("status", REG_STATUS, 32'h0);
    rd("unmapped", 8'h2c, 32'h0, AXI_SLVERR);
    wr(REG_ERR_COUNT, 32'd1544, AXI_OKAY);
    wr(REG_ERR_COUNT, 32'd1545, AXI_SLVERR);
    wr(REG_ERR_COUNT, 32'h800, AXI_SLVERR);
    rd("err_count", REG_ERR_COUNT, 32'd1544);
    for (int r = 0; r < 6; r++) begin
      wr(REG_CTRL, 32'(r) | 32'h10, AXI_OKAY);
      rd("ctrl_rate", REG_CTRL, 32'(r) | 32'h10);
    end
    wr(REG_INT_MASK, 32'h1, AXI_OKAY);
    rd("int_mask", REG_INT_MASK, 32'h1);
    wr(REG_CTRL, 32'h50, AXI_OKAY);
    burst(1544, 1544, 0);
    n = 1 + int'(lfsr[4:0]);
    burst(n, n, 0);
    burst(n, n, 0);
    wr(REG_CTRL, 32'h20, AXI_OKAY);
    np = 0;
    nf = 0;
    wr(REG_TRIGGER, 32'h1, AXI_OKAY);
    settle(60);
    chk("framing_not_internal", 32'h0, 32'(nf));
    wr(REG_CTRL, 32'h60, AXI_OKAY);
    burst(n, 0, n);
    wr(REG_INT_MASK, 32'h0, AXI_OKAY);
    settle(2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(REG_INT_MASK, 32'h1, AXI_OKAY);
    settle(2);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(REG_INT_STAT, 32'h1, AXI_OKAY);
    settle(2);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(REG_ERR_COUNT, 32'h0, AXI_OKAY);
    np = 0;
    wr(REG_CTRL, 32'h51, AXI_OKAY);
    for (int i = 0; i < 4000 && np < 3; i++) @(posedge clk);
    #1;
    chk("rate_gap", 32'd1000, 32'(t1 - t0));
    wr(REG_ERR_COUNT, 32'h5, AXI_OKAY);
    np = 0;
    settle(2100);
    chk("rate_blocked", 32'h0, 32'(np));
    wr(REG_CTRL, 32'h0, AXI_OKAY);
    wr(REG_ERR_COUNT, 32'h0, AXI_OKAY);
    wr(REG_CTRL, 32'h280, AXI_OKAY);
    rd("status_wait", REG_STATUS, 32'h08);
    rd("cnt_bipolar", REG_CNT_BIPOL, CNT_BLANK);
    sync_cmd <= 3'b011;
    settle(8);
    rd("status_run", REG_STATUS, 32'h13);
    rd("cnt_data", REG_CNT_DATA, 32'h0);
    slow <= 1'b1;
    pulse(5'b11111);
    pulse(5'b10000);
    pulse(5'b10000);
    settle(8);
    rd("cnt_data", REG_CNT_DATA, 32'h3);
    for (int k = 0; k < 4; k++) rd("cnt", 8'(REG_CNT_BIPOL + 4 * k), 32'h1);
    wr(REG_CTRL, 32'h0, AXI_OKAY);
    rd("cnt_stopped", REG_CNT_DATA, CNT_BLANK);
    sync_cmd <= 3'b001;
    wr(REG_CTRL, 32'h180, AXI_OKAY);
    settle(8);
    rd("status_mon", REG_STATUS, 32'h11);
    rd("cnt_data_mon", REG_CNT_DATA, CNT_BLANK);
    rd("cnt_bipolar_mon", REG_CNT_BIPOL, 32'h0);
    sync_cmd <= 3'b101;
    settle(5);
    chk("alarm_flag", 32'h1, {31'h0, remote_alarm_flag});
    rd("status_alarm", REG_STATUS, 32'h15);
    @(posedge clk);
    test_done();
  end
endmodule : tb_t1_error_inject_and_count

//--- testbench/tei_line_model.sv
`timescale 1ns/1ps
module tei_line_model
  import tei_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Bench commands.
  input  wire logic [4:0] err_cmd,
  input  wire logic [2:0] sync_cmd,
  input  wire logic       slow,
  // Line toward the block.
  output tei_line_t       line_in
);
  logic [4:0] pend;
  logic       phase;

  // ==========================================================================
  // Line bits, error events held until a line bit carries them, and levels.
  always @(posedge clk) begin
    if (sys_rst) begin
      line_in <= '0;
      pend <= '0;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      line_in.bit_valid <= !slow || phase;
      if (!slow || phase) begin
        {line_in.data_err, line_in.bipolar_violation, line_in.frame_err,
         line_in.crc_err, line_in.frame_alignment_change} <= pend | err_cmd;
        pend <= '0;
      end else begin
        {line_in.data_err, line_in.bipolar_violation, line_in.frame_err,
         line_in.crc_err, line_in.frame_alignment_change} <= '0;
        pend <= pend | err_cmd;
      end
      {line_in.remote_alarm, line_in.pattern_sync, line_in.frame_sync} <= sync_cmd;
    end
  end
endmodule : tei_line_model
